// ---- common/outctl_pkg.sv ----
package outctl_pkg;

  // ==========================================================
  // Geometry
  // ==========================================================
  localparam int unsigned NUM_DRV  = 10;
  localparam int unsigned ADR_W    = 12;
  localparam int unsigned IDX_W    = 9;

  // ==========================================================
  // Register indices (byte address is four times the index)
  // ==========================================================
  localparam logic [IDX_W-1:0] GLOBAL_ALLOW_IDX = 9'h102;
  localparam logic [IDX_W-1:0] STATUS_IDX       = 9'h140;

  localparam logic [NUM_DRV-1:0][IDX_W-1:0] EN_IDX = '{
    0: 9'h108, 1: 9'h10D, 2: 9'h112, 3: 9'h117, 4: 9'h11C,
    5: 9'h121, 6: 9'h126, 7: 9'h12B, 8: 9'h130, 9: 9'h13A};
  localparam logic [NUM_DRV-1:0][IDX_W-1:0] CFG_IDX = '{
    0: 9'h109, 1: 9'h10E, 2: 9'h113, 3: 9'h118, 4: 9'h11D,
    5: 9'h122, 6: 9'h127, 7: 9'h12C, 8: 9'h131, 9: 9'h13B};
  localparam logic [NUM_DRV-1:0][IDX_W-1:0] POL_IDX = '{
    0: 9'h10B, 1: 9'h110, 2: 9'h115, 3: 9'h11A, 4: 9'h11F,
    5: 9'h124, 6: 9'h129, 7: 9'h12E, 8: 9'h133, 9: 9'h138};

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int unsigned ALLOW_BIT   = 0;
  localparam int unsigned EN_BIT      = 1;
  localparam int unsigned DRV_LSB     = 6;
  localparam int unsigned DIS_LSB     = 4;
  localparam int unsigned SYNC_BIT    = 3;
  localparam int unsigned POL_LSB     = 6;
  localparam int unsigned ST_CAL_BIT  = 10;
  localparam int unsigned ST_LOCK_BIT = 11;
  localparam int unsigned ST_PIN_BIT  = 12;

  // ==========================================================
  // Disabled levels
  // ==========================================================
  localparam logic [1:0] DIS_LOW  = 2'h0;
  localparam logic [1:0] DIS_HIGH = 2'h1;

  // ==========================================================
  // Values after reset
  // ==========================================================
  localparam logic       ALLOW_RST = 1'h0;
  localparam logic       EN_RST    = 1'h0;
  localparam logic [1:0] DRV_RST   = 2'h3;
  localparam logic [1:0] DIS_RST   = 2'h0;
  localparam logic       SYNC_RST  = 1'h1;
  localparam logic [1:0] POL_RST   = 2'h0;

  // Software-held settings of one output driver.
  typedef struct packed {
    logic       per_driver_enable;
    logic [1:0] single_ended_drive_select;
    logic [1:0] disabled_level_select;
    logic       glitchless_disable_enable;
    logic [1:0] pin_polarity_select;
  } drv_cfg_t;

  localparam drv_cfg_t DRV_CFG_RST = '{
    per_driver_enable:         EN_RST,
    single_ended_drive_select: DRV_RST,
    disabled_level_select:     DIS_RST,
    glitchless_disable_enable: SYNC_RST,
    pin_polarity_select:       POL_RST};

  // Disable sources shared by every driver.
  typedef struct packed {
    logic global_output_allow;
    logic calibration_in_progress;
    logic loss_of_lock;
    logic external_enable_pin_n;
  } gate_src_t;

endpackage

// ---- hw/lvcmos_outctl.sv ----
`timescale 1ns/1ps

// How it works
// [R1] Any disabling source forces driver to disabled state.
// [R2] Global allow low disables all drivers.
// [R3] Per-driver enable bit one, zero disables it.
// [R4] Two-bit drive select field, codes pick impedance.
// [R5] Software should pick code three plus resistor.
// [R6] Single-ended driver outputs clock on both pins.
// [R7] Polarity field sets true and complement phase.
// [R8] Disabled driver holds low, high or mid.
// [R9] Glitchless bit delays enable change to period end; the code applies it at any sample where the source clock is low.
// [R10] Effective enable is AND of all conditions.
module lvcmos_outctl
  import outctl_pkg::*;
(
  input  wire logic                 SYS_CLK,
  input  wire logic                 RST_N,
  input  wire logic                 CYC_I,
  input  wire logic                 STB_I,
  input  wire logic                 WE_I,
  input  wire logic [ADR_W-1:0]     ADR_I,
  input  wire logic [3:0]           SEL_I,
  input  wire logic [31:0]          DAT_I,
  output logic      [31:0]          DAT_O,
  output logic                      ACK_O,
  input  wire logic                 CALIBRATION_IN_PROGRESS,
  input  wire logic                 LOSS_OF_LOCK,
  input  wire logic                 EXTERNAL_ENABLE_PIN_N,
  input  wire logic [NUM_DRV-1:0]   DRIVER_CLK,
  output logic      [NUM_DRV-1:0]   TRUE_CLOCK_PIN,
  output logic      [NUM_DRV-1:0]   COMPLEMENT_CLOCK_PIN,
  output logic      [NUM_DRV-1:0]   DISABLED_MID,
  output logic      [2*NUM_DRV-1:0] SINGLE_ENDED_DRIVE_SELECT
);

  // ==========================================================
  // Bus decode
  // ==========================================================
  logic             ack_q;
  logic [31:0]      dat_q;
  logic [31:0]      rd_word;
  logic             bus_req;
  logic             wr_take;
  logic             rd_take;
  logic             in_range;
  logic [IDX_W-1:0] idx;

  // A new access is taken only while no answer is pending, so a
  // held request is taken again every second cycle.
  assign bus_req  = CYC_I & STB_I & ~ack_q;
  assign wr_take  = bus_req & WE_I & SEL_I[0];
  assign rd_take  = bus_req & ~WE_I;
  assign in_range = ~ADR_I[ADR_W-1];
  assign idx      = ADR_I[IDX_W+1:2];

  logic hit_allow;
  logic hit_status;

  assign hit_allow  = in_range & (idx == GLOBAL_ALLOW_IDX);
  assign hit_status = in_range & (idx == STATUS_IDX);

  // ==========================================================
  // Shared disable sources
  // ==========================================================
  logic      allow_q;
  logic      allow_d;
  gate_src_t src;
  logic      common_ok;

  assign allow_d = (wr_take & hit_allow) ? DAT_I[ALLOW_BIT] : allow_q;

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      allow_q <= ALLOW_RST;
    end else begin
      allow_q <= allow_d;
    end
  end

  assign src.global_output_allow     = allow_q;
  assign src.calibration_in_progress = CALIBRATION_IN_PROGRESS;
  assign src.loss_of_lock            = LOSS_OF_LOCK;
  assign src.external_enable_pin_n   = EXTERNAL_ENABLE_PIN_N;

  // Allow high releases the global gate only; the other sources
  // still apply below.
  assign common_ok = src.global_output_allow        // [R2]
                   & ~src.calibration_in_progress   // [R1]
                   & ~src.loss_of_lock              // [R1]
                   & ~src.external_enable_pin_n;    // [R1]

  // ==========================================================
  // Per-driver logic
  // ==========================================================
  drv_cfg_t [NUM_DRV-1:0]   cfg_q;
  logic     [NUM_DRV-1:0]   applied_q;
  logic     [NUM_DRV-1:0]   eff_en;
  logic     [NUM_DRV-1:0][7:0] rd_part;
  logic     [NUM_DRV-1:0]   any_hit;

  genvar g;
  generate
    for (g = 0; g < NUM_DRV; g = g + 1) begin : g_drv
      logic     hit_en;
      logic     hit_cfg;
      logic     hit_pol;
      drv_cfg_t cfg_d;
      logic     applied_d;
      logic     period_edge;
      logic     true_inv;
      logic     comp_inv;
      logic     true_d;
      logic     comp_d;
      logic     dis_level;
      logic     mid_d;
      logic [7:0] en_byte;
      logic [7:0] cfg_byte;
      logic [7:0] pol_byte;

      assign hit_en  = in_range & (idx == EN_IDX[g]);
      assign hit_cfg = in_range & (idx == CFG_IDX[g]);
      assign hit_pol = in_range & (idx == POL_IDX[g]);
      assign any_hit[g] = hit_en | hit_cfg | hit_pol;

      // Write side: each field only moves on a write to its byte.
      assign cfg_d.per_driver_enable = (wr_take & hit_en) ?
          DAT_I[EN_BIT] : cfg_q[g].per_driver_enable;           // [R3]
      assign cfg_d.single_ended_drive_select = (wr_take & hit_cfg) ?
          DAT_I[DRV_LSB +: 2] : cfg_q[g].single_ended_drive_select; // [R4]
      assign cfg_d.disabled_level_select = (wr_take & hit_cfg) ?
          DAT_I[DIS_LSB +: 2] : cfg_q[g].disabled_level_select; // [R8]
      assign cfg_d.glitchless_disable_enable = (wr_take & hit_cfg) ?
          DAT_I[SYNC_BIT] : cfg_q[g].glitchless_disable_enable; // [R9]
      assign cfg_d.pin_polarity_select = (wr_take & hit_pol) ?
          DAT_I[POL_LSB +: 2] : cfg_q[g].pin_polarity_select;   // [R7]

      // Read side: reserved bits come back as zero.
      assign en_byte  = {6'h00, cfg_q[g].per_driver_enable, 1'h0};
      assign cfg_byte = {cfg_q[g].single_ended_drive_select,
                         cfg_q[g].disabled_level_select,
                         cfg_q[g].glitchless_disable_enable, 3'h0};
      assign pol_byte = {cfg_q[g].pin_polarity_select, 6'h00};
      assign rd_part[g] = hit_en  ? en_byte  :
                          hit_cfg ? cfg_byte :
                          hit_pol ? pol_byte : 8'h00;

      // Effective enable: every source must agree.
      assign eff_en[g] = common_ok & cfg_q[g].per_driver_enable; // [R10] [R1] [R3]

      // Glitchless mode only lets the gate move while the source
      // clock is low, so a high phase is never cut short and a
      // turn-on always starts with a whole high phase.
      assign period_edge = ~DRIVER_CLK[g];
      assign applied_d = (~cfg_q[g].glitchless_disable_enable
                          | period_edge) ? eff_en[g]
                                         : applied_q[g];        // [R9]

      // Phase map 00 none, 01 complement, 10 both, 11 true.
      assign true_inv = cfg_q[g].pin_polarity_select[1];        // [R7]
      assign comp_inv = cfg_q[g].pin_polarity_select[1]
                      ^ cfg_q[g].pin_polarity_select[0];        // [R7]

      // Held level while disabled; mid has no logic level, so the
      // pins rest low and a separate flag tells the pad to float
      // to its common-mode bias.
      assign dis_level = (cfg_q[g].disabled_level_select == DIS_HIGH); // [R8]
      assign mid_d     = ~applied_d
                       & cfg_q[g].disabled_level_select[1];     // [R8]

      assign true_d = applied_d ? (DRIVER_CLK[g] ^ true_inv)
                                : (dis_level & ~mid_d);         // [R6] [R1]
      assign comp_d = applied_d ? (DRIVER_CLK[g] ^ comp_inv)
                                : (dis_level & ~mid_d);         // [R6] [R1]

      always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
          cfg_q[g] <= DRV_CFG_RST;
        end else begin
          cfg_q[g] <= cfg_d;
        end
      end

      always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
          applied_q[g]            <= 1'h0;
          TRUE_CLOCK_PIN[g]       <= 1'h0;
          COMPLEMENT_CLOCK_PIN[g] <= 1'h0;
          DISABLED_MID[g]         <= 1'h0;
        end else begin
          applied_q[g]            <= applied_d;
          TRUE_CLOCK_PIN[g]       <= true_d;
          COMPLEMENT_CLOCK_PIN[g] <= comp_d;
          DISABLED_MID[g]         <= mid_d;
        end
      end

      // The drive code goes straight to the pad; it has no effect
      // on the logic levels above.
      always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
          SINGLE_ENDED_DRIVE_SELECT[2*g +: 2] <= DRV_RST;
        end else begin
          SINGLE_ENDED_DRIVE_SELECT[2*g +: 2] <=
              cfg_d.single_ended_drive_select;                  // [R4]
        end
      end
    end
  endgenerate

  // ==========================================================
  // Read data
  // ==========================================================
  logic [7:0]  drv_rd;
  logic [31:0] status_word;

  always_comb begin
    drv_rd = 8'h00;
    for (int i = 0; i < NUM_DRV; i++) begin
      drv_rd = drv_rd | rd_part[i];
    end
  end

  assign status_word = {19'h00000,
                        src.external_enable_pin_n,
                        src.loss_of_lock,
                        src.calibration_in_progress,
                        applied_q};

  // Unmapped addresses read as zero and ignore writes.
  assign rd_word = hit_allow  ? {31'h00000000, allow_q} :
                   hit_status ? status_word :
                   (|any_hit) ? {24'h000000, drv_rd} : 32'h00000000;

  // ==========================================================
  // Bus answer
  // ==========================================================
  // One wait state: ack rises the cycle after the request is
  // taken and falls the next, even if the master keeps the strobe.
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_q <= 1'h0;
    end else begin
      ack_q <= bus_req;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      dat_q <= 32'h00000000;
    end else if (rd_take) begin
      dat_q <= rd_word;
    end
  end

  assign ACK_O = ack_q;
  assign DAT_O = dat_q;

endmodule

// ---- tb/drv_clk_src.sv ----
`timescale 1ns/1ps
// ==========================================================
// Board-side source clocks and enable pin
// ==========================================================
// Even drivers toggle every cycle and odd drivers every two cycles, so each
// source clock is low within any three cycles and gate changes always land.
module drv_clk_src
  import outctl_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire logic               pin_off,
  output logic      [NUM_DRV-1:0] driver_clk,
  output logic                    enable_pin_n
);
  logic [1:0] cnt_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) cnt_q <= 2'h0;
    else cnt_q <= cnt_q + 2'h1;
  end
  assign driver_clk   = {5{cnt_q[1], cnt_q[0]}};
  assign enable_pin_n = pin_off;
endmodule

// ---- tb/outctl_assertions.sv ----
`timescale 1ns/1ps
module outctl_checker
  import outctl_pkg::*;
(
  input wire logic                 SYS_CLK,
  input wire logic                 RST_N,
  input wire logic                 CYC_I,
  input wire logic                 STB_I,
  input wire logic                 WE_I,
  input wire logic [3:0]           SEL_I,
  input wire logic [31:0]          DAT_O,
  input wire logic                 ACK_O,
  input wire logic                 CALIBRATION_IN_PROGRESS,
  input wire logic                 LOSS_OF_LOCK,
  input wire logic                 EXTERNAL_ENABLE_PIN_N,
  input wire logic [NUM_DRV-1:0]   TRUE_CLOCK_PIN,
  input wire logic [NUM_DRV-1:0]   COMPLEMENT_CLOCK_PIN,
  input wire logic [NUM_DRV-1:0]   DISABLED_MID,
  input wire logic [2*NUM_DRV-1:0] SINGLE_ENDED_DRIVE_SELECT
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  wire logic taken    = CYC_I && STB_I && !ACK_O;
  wire logic wr_taken = taken && WE_I && SEL_I[0];
  wire logic pins_eq  = TRUE_CLOCK_PIN == COMPLEMENT_CLOCK_PIN;
  // ==========================================================
  // Properties
  // ==========================================================
  // Five cycles cover the wait for a low source clock plus the pin register.
  property p_ack; taken |=> ACK_O ##1 !ACK_O; endproperty
  property p_dat; $changed(DAT_O) |-> ACK_O; endproperty
  property p_drv_rst; $rose(RST_N) |-> SINGLE_ENDED_DRIVE_SELECT == {2*NUM_DRV{1'b1}}; endproperty
  property p_drv_wr;
    $changed(SINGLE_ENDED_DRIVE_SELECT) |-> $past(wr_taken) || $past(wr_taken, 2);
  endproperty
  property p_cal; CALIBRATION_IN_PROGRESS [*5] |-> pins_eq; endproperty
  property p_unlock; LOSS_OF_LOCK [*5] |-> pins_eq; endproperty
  property p_pin; EXTERNAL_ENABLE_PIN_N [*5] |-> pins_eq; endproperty
  property p_mid; (DISABLED_MID & (TRUE_CLOCK_PIN | COMPLEMENT_CLOCK_PIN)) == '0; endproperty
  a_ack: assert property (p_ack) else $error("ack is not one pulse");
  a_dat: assert property (p_dat) else $error("read data moved without ack");
  a_drv_rst: assert property (p_drv_rst) else $error("drive select reset wrong");
  a_drv_wr: assert property (p_drv_wr) else $error("drive select moved without write");
  a_cal: assert property (p_cal) else $error("driver active in calibration");
  a_unlock: assert property (p_unlock) else $error("driver active without lock");
  a_pin: assert property (p_pin) else $error("driver active with pin high");
  a_mid: assert property (p_mid) else $error("mid level with pin driven");
  c_ack: cover property (taken ##1 ACK_O);
  c_mid: cover property ($rose(|DISABLED_MID));
  c_cal: cover property (CALIBRATION_IN_PROGRESS [*5]);
endmodule
bind lvcmos_outctl outctl_checker chk_u (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .CYC_I(CYC_I),
  .STB_I(STB_I), .WE_I(WE_I), .SEL_I(SEL_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
  .CALIBRATION_IN_PROGRESS(CALIBRATION_IN_PROGRESS), .LOSS_OF_LOCK(LOSS_OF_LOCK),
  .EXTERNAL_ENABLE_PIN_N(EXTERNAL_ENABLE_PIN_N), .TRUE_CLOCK_PIN(TRUE_CLOCK_PIN),
  .COMPLEMENT_CLOCK_PIN(COMPLEMENT_CLOCK_PIN), .DISABLED_MID(DISABLED_MID),
  .SINGLE_ENDED_DRIVE_SELECT(SINGLE_ENDED_DRIVE_SELECT));

// ---- tb/lvcmos_outctl_test.sv ----
`timescale 1ns/1ps
module lvcmos_outctl_test;
  import outctl_pkg::*;
  logic                   clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic                   cal = 1'b0, unlocked = 1'b0, pin_off = 1'b0;
  logic [ADR_W-1:0]       adr = '0;
  logic [3:0]             sel = 4'hF;
  logic [31:0]            wdat = '0, rd;
  logic [1:0]             pol [NUM_DRV];
  wire  [31:0]            rdat;
  wire                    ack, pin_n;
  wire  [NUM_DRV-1:0]     dclk, tpin, cpin, mid;
  wire  [2*NUM_DRV-1:0]   dsel;
  int                     err_count = 0, n_tests = 0, cycles = 0;
  always #5 clk = ~clk;
  drv_clk_src src_u (.sys_clk(clk), .rst_n(rst_n), .pin_off(pin_off), .driver_clk(dclk),
    .enable_pin_n(pin_n));
  lvcmos_outctl dut_u (.SYS_CLK(clk), .RST_N(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack),
    .CALIBRATION_IN_PROGRESS(cal), .LOSS_OF_LOCK(unlocked), .EXTERNAL_ENABLE_PIN_N(pin_n),
    .DRIVER_CLK(dclk), .TRUE_CLOCK_PIN(tpin), .COMPLEMENT_CLOCK_PIN(cpin),
    .DISABLED_MID(mid), .SINGLE_ENDED_DRIVE_SELECT(dsel));
  // ==========================================================
  // Checks and bus tasks
  // ==========================================================
  task complete_run;
    if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task chk_pin(input logic [NUM_DRV-1:0] got, input logic [NUM_DRV-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t pins %h exp %h", $time, got, exp);
    end
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end
  // Ack is read before the slave's own update at the edge, so it is the sampled value.
  task wb(input logic w, input logic [ADR_W-1:0] a, input logic [7:0] d, input logic [3:0] s);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= {24'h0, d}; sel <= s;
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task wr(input logic [IDX_W-1:0] i, input logic [7:0] d);
    wb(1'b1, {1'b0, i, 2'b00}, d, 4'hF);
  endtask
  task rdc(input logic [IDX_W-1:0] i, input logic [31:0] exp);
    wb(1'b0, {1'b0, i, 2'b00}, 8'h00, 4'hF);
    chk_reg(rd, exp);
  endtask
  // Disabled drivers are expected at the level given in lvl on both pins.
  task pins(input logic [NUM_DRV-1:0] on, input logic [NUM_DRV-1:0] lvl);
    logic [NUM_DRV-1:0] c, et, ec;
    repeat (6) @(posedge clk);
    repeat (3) begin
      @(negedge clk);
      c = dclk;
      @(negedge clk);
      for (int i = 0; i < NUM_DRV; i++) begin
        et[i] = on[i] ? c[i] ^ pol[i][1] : lvl[i];
        ec[i] = on[i] ? c[i] ^ pol[i][1] ^ pol[i][0] : lvl[i];
      end
      chk_pin(tpin, et);
      chk_pin(cpin, ec);
    end
  endtask
  // ==========================================================
  // Sequence
  // ==========================================================
  initial begin
    for (int i = 0; i < NUM_DRV; i++) pol[i] = 2'(i);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk_reg({12'h0, dsel}, 32'h000FFFFF);
    rdc(GLOBAL_ALLOW_IDX, 32'h0);
    for (int i = 0; i < NUM_DRV; i++) begin
      rdc(EN_IDX[i], 32'h0);
      rdc(CFG_IDX[i], 32'hC8);
      rdc(POL_IDX[i], 32'h0);
    end
    wb(1'b0, 12'h800, 8'h00, 4'hF);
    chk_reg(rd, 32'h0);
    pins('0, '0);
    wr(GLOBAL_ALLOW_IDX, 8'h01);
    for (int i = 0; i < NUM_DRV; i++) begin
      wr(EN_IDX[i], 8'h02);
      wr(CFG_IDX[i], 8'hC0);
      wr(POL_IDX[i], {pol[i], 6'h00});
    end
    pins('1, '0);
    rdc(POL_IDX[3], 32'hC0);
    rdc(STATUS_IDX, 32'h3FF);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      {cal, unlocked, pin_off} <= 3'b100 >> k;
      pins('0, '0);
      rdc(STATUS_IDX, 32'h400 << k);
    end
    @(posedge clk);
    {cal, unlocked, pin_off} <= 3'b000;
    wr(EN_IDX[0], 8'h00);
    wr(CFG_IDX[1], 8'hD0);
    wr(EN_IDX[1], 8'h00);
    wr(CFG_IDX[2], 8'hE0);
    wr(EN_IDX[2], 8'h00);
    pins(10'h3F8, 10'h002);
    chk_pin(mid, 10'h004);
    wb(1'b1, {1'b0, EN_IDX[0], 2'b00}, 8'h02, 4'hE);
    rdc(EN_IDX[0], 32'h0);
    wr(CFG_IDX[0], 8'h40);
    @(negedge clk);
    chk_reg({30'h0, dsel[1:0]}, 32'h1);
    rdc(CFG_IDX[0], 32'h40);
    // Driver 9 turns glitchless and calibration starts in its high phase:
    // it must finish that phase while the free-running driver 8 stops at once.
    wr(CFG_IDX[9], 8'hC8);
    do @(negedge clk); while (dclk[9:8] !== 2'b10);
    @(posedge clk);
    cal <= 1'b1;
    repeat (2) @(negedge clk);
    chk_pin(tpin & 10'h300, 10'h200);
    repeat (3) @(negedge clk);
    chk_pin(tpin & 10'h300, 10'h000);
    @(posedge clk);
    cal <= 1'b0;
    wr(GLOBAL_ALLOW_IDX, 8'h00);
    pins('0, 10'h002);
    complete_run();
  end
endmodule
